// File: core/swc_pkg.sv
// swc_pkg: constants shared by the sleep / wake-up controller
// assumes a single 40 MHz clock domain and a synchronous active-high reset
package swc_pkg;

    // clock rate and oscillator restart time
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned OSC_START_NS    = 1000;
    localparam int unsigned OSC_START_CYC   = (OSC_START_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // status byte field positions and reset values
    localparam int unsigned STAT_PD_BIT     = 3;
    localparam int unsigned STAT_TO_BIT     = 4;
    localparam logic        PD_RESET_VAL    = 1'b1;
    localparam logic        TO_RESET_VAL    = 1'b1;

    // vector taken after a wake-up with interrupts on
    localparam logic [12:0] INT_VECTOR      = 13'h0004;

    // register port map
    localparam logic [2:0]  REG_STATUS      = 3'h0;
    localparam logic [2:0]  REG_WAKE_EN     = 3'h1;
    localparam logic [2:0]  REG_IRQ_STAT    = 3'h2;
    localparam logic [2:0]  REG_IRQ_EN      = 3'h3;
    localparam logic [2:0]  REG_IRQ_CLR     = 3'h4;
    localparam logic [2:0]  REG_CTRL        = 3'h5;

    // number of peripheral wake sources
    localparam int unsigned NUM_PERIPH      = 9;

    // controller events seen by the interrupt logic
    localparam int unsigned EV_ENTER        = 0;
    localparam int unsigned EV_WAKE_INT     = 1;
    localparam int unsigned EV_WAKE_WDT     = 2;
    localparam int unsigned EV_NOP_SLEEP    = 3;
    localparam int unsigned NUM_EV          = 4;

    // sleep sequencer states
    typedef enum logic [4:0] {
        SWC_RUN     = 5'b00001,
        SWC_ENTER   = 5'b00010,
        SWC_SLEEP   = 5'b00100,
        SWC_RESTART = 5'b01000,
        SWC_RESUME  = 5'b10000
    } swc_state_e;

endpackage

// File: core/swc_sync.sv
// swc_sync: two-flop synchroniser for a bundle of asynchronous levels
// assumes levels held at least two clock cycles
`timescale 1ns/100ps
module swc_sync
    import swc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second stage
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule

// File: core/swc_osc_restart.sv
// swc_osc_restart: oscillator driver gate and restart timer
// assumes its clock keeps running while the driver is off
`timescale 1ns/100ps
module swc_osc_restart
    import swc_pkg::*;
#(
    parameter int unsigned START_CYC = OSC_START_CYC
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // control
    input  wire logic i_stop,
    input  wire logic i_start,
    // status
    output logic      o_osc_on,
    output logic      o_stable
);

    localparam int unsigned CW = $clog2(START_CYC + 1);
    localparam logic [CW-1:0] START_LOAD = CW'(START_CYC);

    logic [CW-1:0] cnt_r;

    // stop wins so a late restart cannot leave clocks on in sleep
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_osc_on <= 1'b1;
        end else if (i_stop) begin
            o_osc_on <= 1'b0;
        end else if (i_start) begin
            o_osc_on <= 1'b1;
        end
    end

    // start-up count before the clock is stable
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (i_stop) begin
            cnt_r <= START_LOAD;
        end else if (o_osc_on && cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
        end
    end

    assign o_stable = o_osc_on && (cnt_r == '0);

endmodule

// File: core/swc_top.sv
// swc_top: power-down (sleep) and wake-up controller of a small 8-bit core
// assumes one i_sleep_exec pulse per sleep instruction; the core obeys o_core_hold
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
module swc_top
    import swc_pkg::*;
#(
    parameter int unsigned NPER      = NUM_PERIPH,
    parameter int unsigned PINS      = 8,
    parameter int unsigned START_CYC = OSC_START_CYC
) (
    // clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    // register port
    input  wire logic [2:0]      i_addr,
    input  wire logic [7:0]      i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [7:0]      o_rdata,
    // instruction sequencer
    input  wire logic            i_sleep_exec,
    input  wire logic            i_global_interrupt_enable,
    input  wire logic            i_wdt_enable,
    output logic                 o_core_hold,
    output logic                 o_prefetch_next,
    output logic                 o_vector_req,
    output logic      [12:0]     o_vector_addr,
    output logic                 o_resume,
    // wake sources (asynchronous pins and flags)
    input  wire logic            i_external_reset_pin_n,
    input  wire logic            i_ext_int_flag,
    input  wire logic            i_ext_int_en,
    input  wire logic            i_port_b_change_flag,
    input  wire logic            i_port_b_change_en,
    input  wire logic [NPER-1:0] i_periph_flag,
    input  wire logic [NPER-1:0] i_periph_en,
    input  wire logic            i_wdt_timeout,
    // watchdog control
    output logic                 o_wdt_clear,
    // power and pins
    output logic                 o_osc_drive_on,
    output logic                 o_clocks_gated,
    output logic                 o_device_reset,
    input  wire logic [PINS-1:0] i_pin_out,
    input  wire logic [PINS-1:0] i_pin_oe_n,
    output logic      [PINS-1:0] o_pin_out,
    output logic      [PINS-1:0] o_pin_oe_n,
    // status flags and interrupt
    output logic                 o_power_down_flag,
    output logic                 o_time_out_flag,
    output logic                 o_irq
);

    localparam int unsigned NSYNC = NPER + 4;

    swc_state_e       state_r;
    swc_state_e       state_nxt;
    logic [NSYNC-1:0] raw_async;
    logic [NSYNC-1:0] raw_sync;
    logic             rst_pin_n_s;
    logic             ext_flag_s;
    logic             rbc_flag_s;
    logic             wdt_to_s;
    logic [NPER-1:0]  per_flag_s;
    logic [NPER-1:0]  wake_en_r;
    logic             power_down_flag_r;
    logic             time_out_flag_r;
    logic             int_pending;
    logic             wake_int;
    logic             wake_wdt;
    logic             osc_stop;
    logic             osc_start;
    logic             osc_on;
    logic             osc_stable;
    logic             vec_pending_r;
    logic             sleep_nop;
    logic             freeze_r;
    logic [PINS-1:0]  pin_hold_r;
    logic [PINS-1:0]  oe_hold_r;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] irq_stat_r;
    logic [NUM_EV-1:0] irq_en_r;
    logic             sw_reset_r;

    // any of the given enabled flags active
    function automatic logic any_enabled(input logic [NPER-1:0] f, input logic [NPER-1:0] e,
                                         input logic [NPER-1:0] m);
        any_enabled = |(f & e & m);
    endfunction

    // wake inputs are asynchronous; the pin goes in inverted so a sync reset reads as released
    assign raw_async = {~i_external_reset_pin_n, i_ext_int_flag & i_ext_int_en,
                        i_port_b_change_flag & i_port_b_change_en, i_wdt_timeout, i_periph_flag};

    swc_sync #(
        .WIDTH (NSYNC)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (raw_async),
        .o_sync  (raw_sync)
    );

    assign rst_pin_n_s = !raw_sync[NPER+3];
    assign ext_flag_s  = raw_sync[NPER+2];
    assign rbc_flag_s  = raw_sync[NPER+1];
    assign wdt_to_s    = raw_sync[NPER];
    assign per_flag_s  = raw_sync[NPER-1:0];

    // only listed peripherals are wired; the mask gates them
    // the global enable plays no part in wake-up
    assign int_pending = ext_flag_s | rbc_flag_s | any_enabled(per_flag_s, i_periph_en, wake_en_r);

    // pending interrupt makes sleep a no-operation
    assign sleep_nop = (state_r == SWC_RUN) && i_sleep_exec && int_pending;

    // wake causes while asleep
    assign wake_int  = int_pending;
    assign wake_wdt  = i_wdt_enable && wdt_to_s;

    // sleep sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SWC_RUN: begin
                if (i_sleep_exec && !int_pending) begin
                    state_nxt = SWC_ENTER;
                end
            end
            SWC_ENTER: begin
                state_nxt = SWC_SLEEP;                                              // entry always completes
            end
            SWC_SLEEP: begin
                if (wake_int || wake_wdt) begin
                    state_nxt = SWC_RESTART;
                end
            end
            SWC_RESTART: begin
                if (osc_stable) begin
                    state_nxt = SWC_RESUME;
                end
            end
            SWC_RESUME: begin
                state_nxt = SWC_RUN;
            end
            default: begin
                state_nxt = SWC_RUN;
            end
        endcase
    end

    // the reset pin restarts the device
    always_ff @(posedge i_mclk) begin
        if (i_rst || !rst_pin_n_s || sw_reset_r) begin
            state_r <= SWC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // device reset while the pin is low
    assign o_device_reset = !rst_pin_n_s;

    // power-down flag: set by i_rst and the reset pin, cleared by sleep
    always_ff @(posedge i_mclk) begin
        if (i_rst || !rst_pin_n_s) begin
            power_down_flag_r <= PD_RESET_VAL;
        end else if (state_r == SWC_ENTER) begin
            power_down_flag_r <= 1'b0;
        end
    end

    // time-out flag: set on entry, cleared by a watchdog wake
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            time_out_flag_r <= TO_RESET_VAL;
        end else if (state_r == SWC_ENTER) begin
            time_out_flag_r <= 1'b1;
        end else if (state_r == SWC_SLEEP && wake_wdt && !wake_int) begin
            time_out_flag_r <= 1'b0;
        end
    end

    assign o_power_down_flag = power_down_flag_r;
    assign o_time_out_flag   = time_out_flag_r;

    // clear the watchdog on entry; it keeps counting
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_wdt_clear <= 1'b0;
        end else begin
            o_wdt_clear <= (state_nxt == SWC_ENTER) && (state_r == SWC_RUN) && i_wdt_enable;
        end
    end

    // driver stops on entry, restarts on a non-reset wake
    assign osc_stop  = (state_r == SWC_ENTER);
    assign osc_start = (state_r == SWC_SLEEP) && (wake_int || wake_wdt);

    swc_osc_restart #(
        .START_CYC (START_CYC)
    ) u_osc (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst || !rst_pin_n_s || sw_reset_r),
        .i_stop   (osc_stop),
        .i_start  (osc_start),
        .o_osc_on (osc_on),
        .o_stable (osc_stable)
    );

    assign o_osc_drive_on = osc_on;
    // no on-chip clock while the driver is off
    assign o_clocks_gated = !osc_on;

    // hold the core from entry until the clock is stable
    assign o_core_hold = (state_r != SWC_RUN) && (state_r != SWC_RESUME);

    // next instruction fetched while sleep executes
    assign o_prefetch_next = (state_r == SWC_RUN) && i_sleep_exec;

    // resume pulse: continue at the prefetched instruction
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_resume <= 1'b0;
        end else begin
            o_resume <= (state_r == SWC_RESUME);
        end
    end

    // with the global enable set, vector after the next instruction
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            vec_pending_r <= 1'b0;
        end else if (state_r == SWC_SLEEP && wake_int && i_global_interrupt_enable) begin
            vec_pending_r <= 1'b1;
        end else if (o_resume) begin
            vec_pending_r <= 1'b0;
        end
    end

    // vector one cycle after resume, after the next instruction
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_vector_req  <= 1'b0;
            o_vector_addr <= '0;
        end else begin
            o_vector_req  <= o_resume && vec_pending_r;
            o_vector_addr <= INT_VECTOR;
        end
    end

    // pin freeze from entry until resume; any restart releases the pins
    always_ff @(posedge i_mclk) begin
        if (i_rst || !rst_pin_n_s || sw_reset_r) begin
            freeze_r   <= 1'b0;
            pin_hold_r <= '0;
            oe_hold_r  <= '1;
        end else begin
            if (state_r == SWC_RUN && state_nxt == SWC_ENTER) begin
                freeze_r   <= 1'b1;
                pin_hold_r <= i_pin_out;
                oe_hold_r  <= i_pin_oe_n;
            end else if (state_r == SWC_RESUME) begin
                freeze_r <= 1'b0;
            end
        end
    end

    // frozen: high, low and released pins alike
    assign o_pin_out  = freeze_r ? pin_hold_r : i_pin_out;
    assign o_pin_oe_n = freeze_r ? oe_hold_r  : i_pin_oe_n;

    // controller events for the interrupt status
    assign ev[EV_ENTER]     = osc_stop;
    assign ev[EV_WAKE_INT]  = osc_start && wake_int;
    assign ev[EV_WAKE_WDT]  = osc_start && wake_wdt && !wake_int;
    assign ev[EV_NOP_SLEEP] = sleep_nop;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_stat_r <= '0;
        end else if (i_wr && i_addr == REG_IRQ_CLR) begin
            irq_stat_r <= (irq_stat_r & ~i_wdata[NUM_EV-1:0]) | ev;
        end else begin
            irq_stat_r <= irq_stat_r | ev;
        end
    end

    // software-written enables and control
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_en_r   <= '0;
            wake_en_r  <= '1;
            sw_reset_r <= 1'b0;
        end else begin
            sw_reset_r <= 1'b0;
            if (i_wr && i_addr == REG_IRQ_EN) begin
                irq_en_r <= i_wdata[NUM_EV-1:0];
            end
            if (i_wr && i_addr == REG_WAKE_EN) begin
                wake_en_r <= NPER'(i_wdata);
            end
            if (i_wr && i_addr == REG_CTRL) begin
                sw_reset_r <= i_wdata[0];
            end
        end
    end

    assign o_irq = |(irq_stat_r & irq_en_r);

    // read data the cycle after the strobe; others read zero
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                REG_STATUS: begin
                    o_rdata <= 8'((time_out_flag_r << STAT_TO_BIT) | (power_down_flag_r << STAT_PD_BIT));
                end
                REG_WAKE_EN: begin
                    o_rdata <= 8'(wake_en_r);
                end
                REG_IRQ_STAT: begin
                    o_rdata <= 8'(irq_stat_r);
                end
                REG_IRQ_EN: begin
                    o_rdata <= 8'(irq_en_r);
                end
                default: begin
                    o_rdata <= 8'h00;
                end
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// File: bench/swc_top_sva.sv
// swc_top_sva: port-level checks of the sleep / wake-up controller
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/100ps
module swc_top_sva
    import swc_pkg::*;
#(
    parameter int unsigned START_CYC = OSC_START_CYC
) (
    // clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst,
    // sequencer and wake inputs
    input wire logic        i_sleep_exec,
    input wire logic        i_wdt_enable,
    input wire logic        i_ext_int_flag,
    input wire logic        i_ext_int_en,
    input wire logic        i_external_reset_pin_n,
    // controller outputs
    input wire logic        o_core_hold,
    input wire logic        o_wdt_clear,
    input wire logic        o_power_down_flag,
    input wire logic        o_time_out_flag,
    input wire logic        o_osc_drive_on,
    input wire logic        o_clocks_gated,
    input wire logic        o_device_reset,
    input wire logic        o_resume,
    input wire logic        o_vector_req,
    input wire logic [12:0] o_vector_addr
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // entry and its side effects
    property p_hold_cause;
        $rose(o_core_hold) |-> $past(i_sleep_exec);
    endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("hold without sleep");
    property p_wdt_clear;
        o_wdt_clear |-> $rose(o_core_hold) && $past(i_wdt_enable);
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("stray wdt clear");
    property p_pd_fall;
        $fell(o_power_down_flag) |-> $past(i_sleep_exec, 2);
    endproperty
    a_pd_fall: assert property (p_pd_fall) else $error("stray pd fall");
    property p_to_rise;
        $rose(o_time_out_flag) |-> $past(i_sleep_exec, 2);
    endproperty
    a_to_rise: assert property (p_to_rise) else $error("stray to rise");
    property p_osc_off;
        !o_osc_drive_on |-> o_clocks_gated && o_core_hold;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc off, core runs");

    // wake paths: the synchroniser adds cycles
    property p_rst_pin;
        !i_external_reset_pin_n [*3] |-> o_device_reset;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
    property p_int_wake;
        o_core_hold && !o_osc_drive_on && i_ext_int_flag && i_ext_int_en |-> ##[1:4] o_osc_drive_on;
    endproperty
    a_int_wake: assert property (p_int_wake) else $error("int no wake");
    property p_vector;
        o_vector_req |-> $past(o_resume) && o_vector_addr == INT_VECTOR;
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");
    property p_resume;
        o_resume |-> $past(o_osc_drive_on, START_CYC);
    endproperty
    a_resume: assert property (p_resume) else $error("early resume");

    // main scenarios
    c_vector: cover property (o_vector_req);
    c_to_cleared: cover property ($fell(o_time_out_flag));
    c_reset_pin: cover property (o_device_reset);
endmodule

bind swc_top swc_top_sva #(.START_CYC(START_CYC)) i_swc_top_sva (
    .i_mclk, .i_rst, .i_sleep_exec, .i_wdt_enable, .i_ext_int_flag, .i_ext_int_en,
    .i_external_reset_pin_n, .o_core_hold, .o_wdt_clear, .o_power_down_flag, .o_time_out_flag,
    .o_osc_drive_on, .o_clocks_gated, .o_device_reset, .o_resume, .o_vector_req, .o_vector_addr
);

// File: bench/swc_wake_model.sv
// swc_wake_model: wake sources: pins, peripherals, watchdog
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/100ps
module swc_wake_model
    import swc_pkg::*;
(
    // clock
    input  wire logic                  i_mclk,
    // wake levels
    output logic                       o_rst_pin_n,
    output logic                       o_ext_flag,
    output logic                       o_portb_flag,
    output logic      [NUM_PERIPH-1:0] o_periph_flag,
    output logic                       o_wdt_timeout
);
    // flags idle low; the reset pin is pulled up so sleep stays legal
    initial begin
        o_rst_pin_n = 1'h1;
        o_ext_flag = 1'h0;
        o_portb_flag = 1'h0;
        o_periph_flag = '0;
        o_wdt_timeout = 1'h0;
    end
    // 0 ext pin, 1 port b, 2..10 listed peripherals, 11 watchdog; lag makes a slow source
    // clock-hungry peripherals get no entry: they cannot flag while asleep
    task automatic raise(input int src, input int lag);
        repeat (lag) @(posedge i_mclk);
        if (src == 0) o_ext_flag <= 1'h1;
        else if (src == 1) o_portb_flag <= 1'h1;
        else if (src < 11) o_periph_flag[src-2] <= 1'h1;
        else o_wdt_timeout <= 1'h1;
    endtask
    // software drops every flag
    task automatic drop();
        o_ext_flag <= 1'h0;
        o_portb_flag <= 1'h0;
        o_periph_flag <= '0;
        o_wdt_timeout <= 1'h0;
    endtask
    // reset pin held low for n cycles
    task automatic pull_reset(input int n);
        o_rst_pin_n <= 1'h0;
        repeat (n) @(posedge i_mclk);
        o_rst_pin_n <= 1'h1;
    endtask
endmodule

// File: bench/tb_top.sv
// tb_top: self-checking bench of the sleep / wake-up controller
// assumes swc_wake_model drives wake levels; restart time cut to 4 cycles
`timescale 1ns/100ps
module tb_top
    import swc_pkg::*;
;
    logic                  i_mclk = 1'h0;
    logic                  i_rst = 1'h1;
    logic [2:0]            i_addr = 3'h0;
    logic [7:0]            i_wdata = 8'h00;
    logic                  i_wr = 1'h0, i_rd = 1'h0, i_sleep_exec = 1'h0, i_global_interrupt_enable = 1'h0;
    logic                  i_wdt_enable = 1'h1, i_ext_int_en = 1'h1, i_port_b_change_en = 1'h1;
    logic [NUM_PERIPH-1:0] i_periph_en = 9'h1FF, i_periph_flag;
    logic [7:0]            i_pin_out = 8'hA5, i_pin_oe_n = 8'h0F, o_rdata, o_pin_out, o_pin_oe_n;
    logic                  i_external_reset_pin_n, i_ext_int_flag, i_port_b_change_flag, i_wdt_timeout;
    logic [12:0]           o_vector_addr;
    logic                  o_core_hold, o_prefetch_next, o_vector_req, o_resume, o_wdt_clear, o_osc_drive_on;
    logic                  o_clocks_gated, o_device_reset, o_power_down_flag, o_time_out_flag, o_irq;
    int                    fails = 0;
    int                    check_count = 0;

    swc_top #(.START_CYC(4)) i_swc_top (
        .i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep_exec, .i_global_interrupt_enable,
        .i_wdt_enable, .o_core_hold, .o_prefetch_next, .o_vector_req, .o_vector_addr, .o_resume,
        .i_external_reset_pin_n, .i_ext_int_flag, .i_ext_int_en, .i_port_b_change_flag, .i_port_b_change_en,
        .i_periph_flag, .i_periph_en, .i_wdt_timeout, .o_wdt_clear, .o_osc_drive_on, .o_clocks_gated,
        .o_device_reset, .i_pin_out, .i_pin_oe_n, .o_pin_out, .o_pin_oe_n, .o_power_down_flag,
        .o_time_out_flag, .o_irq
    );
    swc_wake_model i_swc_wake_model (
        .i_mclk, .o_rst_pin_n(i_external_reset_pin_n), .o_ext_flag(i_ext_int_flag),
        .o_portb_flag(i_port_b_change_flag), .o_periph_flag(i_periph_flag), .o_wdt_timeout(i_wdt_timeout)
    );

    // 40 MHz clock
    always #12.5 i_mclk = ~i_mclk;

    // compares: flags and values
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // register port: strobes last one cycle, read data stands only in the next
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_mclk);
        i_wr <= 1'h0;
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_mclk);
        i_rd <= 1'h0;
        @(negedge i_mclk);
        cmp_val("rdata", 16'(exp), 16'(o_rdata));
        @(posedge i_mclk);
    endtask
    task automatic chk_irq(input logic exp);
        @(negedge i_mclk);
        cmp_bit("irq", exp, o_irq);
        @(posedge i_mclk);
    endtask
    // bounded wait, sampled on the falling edge
    task automatic wait_resume();
        int n;
        n = 0;
        while (o_resume !== 1'h1 && n < 40) begin
            @(negedge i_mclk);
            n++;
        end
        cmp_bit("resume", 1'h1, o_resume);
    endtask
    // sleep pulse, watchdog cleared before, no-op after
    task automatic sleep_go(input logic enter);
        i_sleep_exec <= 1'h1;
        @(negedge i_mclk);
        cmp_bit("prefetch", 1'h1, o_prefetch_next);
        @(posedge i_mclk);
        i_sleep_exec <= 1'h0;
        @(negedge i_mclk);
        cmp_bit("hold", enter, o_core_hold);
        cmp_bit("wdt clear", enter & i_wdt_enable, o_wdt_clear);
        repeat (2) @(posedge i_mclk);
    endtask

    task automatic t_regs();
        rd(REG_STATUS, 8'h18);
        rd(REG_WAKE_EN, 8'hFF);
        wr(3'h6, 8'hFF);
        rd(3'h6, 8'h00);
        $display("test regs done");
    endtask
    // interrupt wake; lag 0 raises the flag with the sleep pulse
    task automatic t_int_wake(input logic global_interrupt_enable, input int src, input int lag);
        i_global_interrupt_enable <= global_interrupt_enable;
        fork
            i_swc_wake_model.raise(src, lag);
        join_none
        sleep_go(1'h1);
        i_pin_out <= 8'h5A;
        i_pin_oe_n <= 8'hF0;
        @(negedge i_mclk);
        cmp_bit("pd", 1'h0, o_power_down_flag);
        cmp_bit("to", 1'h1, o_time_out_flag);
        if (lag > 0) begin
            cmp_bit("osc", 1'h0, o_osc_drive_on | ~o_clocks_gated);
            cmp_val("pins", 16'h0FA5, {o_pin_oe_n, o_pin_out});
        end
        wait_resume();
        @(negedge i_mclk);
        cmp_bit("vector", global_interrupt_enable, o_vector_req);
        if (global_interrupt_enable) cmp_val("vaddr", 16'h0004, 16'(o_vector_addr));
        @(posedge i_mclk);
        i_swc_wake_model.drop();
        i_pin_out <= 8'hA5;
        i_pin_oe_n <= 8'h0F;
        repeat (4) @(posedge i_mclk);
        $display("test int wake src %0d done", src);
    endtask
    // disabled source cannot wake; the watchdog does, clearing time-out
    task automatic t_wdt();
        i_ext_int_en <= 1'h0;
        i_swc_wake_model.raise(0, 0);
        sleep_go(1'h1);
        repeat (10) @(negedge i_mclk);
        cmp_bit("asleep", 1'h1, o_core_hold & ~o_osc_drive_on);
        @(posedge i_mclk);
        i_swc_wake_model.raise(11, 0);
        wait_resume();
        cmp_bit("to", 1'h0, o_time_out_flag);
        @(posedge i_mclk);
        i_swc_wake_model.drop();
        i_ext_int_en <= 1'h1;
        repeat (4) @(posedge i_mclk);
        rd(REG_STATUS, 8'h00);
        $display("test watchdog wake done");
    endtask
    // pending flag: sleep is a no-operation whose event raises the interrupt
    task automatic t_nop_irq();
        wr(REG_IRQ_CLR, 8'h0F);
        wr(REG_IRQ_EN, 8'h08);
        i_swc_wake_model.raise(1, 0);
        repeat (4) @(posedge i_mclk);
        sleep_go(1'h0);
        @(negedge i_mclk);
        cmp_bit("to kept", 1'h0, o_time_out_flag);
        @(posedge i_mclk);
        rd(REG_IRQ_STAT, 8'h08);
        chk_irq(1'h1);
        wr(REG_IRQ_EN, 8'h00);
        chk_irq(1'h0);
        wr(REG_IRQ_EN, 8'h08);
        wr(REG_IRQ_CLR, 8'h08);
        chk_irq(1'h0);
        i_swc_wake_model.drop();
        repeat (4) @(posedge i_mclk);
        $display("test no-op sleep and irq done");
    endtask
    // reset pin during sleep restarts the device instead of resuming
    task automatic t_reset_pin();
        sleep_go(1'h1);
        i_swc_wake_model.pull_reset(4);
        @(negedge i_mclk);
        cmp_bit("dev reset", 1'h1, o_device_reset);
        repeat (4) @(negedge i_mclk);
        cmp_bit("hold", 1'h0, o_core_hold);
        cmp_bit("pd", 1'h1, o_power_down_flag);
        cmp_bit("to", 1'h1, o_time_out_flag);
        @(posedge i_mclk);
        $display("test reset pin done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // about 400 cycles of tests; 8000 is ample
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'h0;
        t_regs();
        t_int_wake(1'h0, 0, 8);
        t_int_wake(1'h1, 0, 0);
        t_wdt();
        t_nop_irq();
        for (int k = 1; k < 11; k++) t_int_wake(k[0], k, 8);
        t_reset_pin();
        report_and_stop();
    end
endmodule
